// ---- src/timer16_counter_input_capture.sv ----
// 16-bit up/down timer counter with input capture, Wishbone slave
//
// The implementer's own choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
module timer16_counter_input_capture (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire timer16_pkg::wb_req_t wb_req_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic capture_pin_i,
    input wire logic comparator_output_i,
    input wire logic external_count_pin_i,
    input wire logic capture_irq_ack_i,
    input wire logic overflow_irq_ack_i,
    output logic capture_irq_o,
    output logic overflow_irq_o,
    output logic top_o,
    output logic bottom_o,
    output logic [15:0] count_value_o
);
    import timer16_pkg::*;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0] control_reg_a_reg;
    logic [7:0] control_reg_b_reg;
    logic [7:0] comparator_ctrl_status_reg;
    logic [7:0] irq_enable_reg;
    logic [7:0] holding_reg;
    logic [15:0] count_value_reg;
    logic [15:0] count_value_next;
    logic [15:0] capture_value_reg;
    logic [15:0] compare_a_reg;
    logic count_down_reg;
    logic count_down_next;
    logic overflow_flag_reg;
    logic capture_flag_reg;
    logic ack_reg;
    logic [31:0] dat_reg;
    logic [PRESC_WIDTH-1:0] presc_reg;
    logic [2:0] ext_sync_reg;
    logic [1:0] pin_sync_reg;
    logic [1:0] comp_sync_reg;
    logic [FILTER_SAMPLES-2:0] filt_hist_reg;
    logic filt_out_reg;
    logic det_prev_reg;

    // ----------------------------------------------------------------
    // Decoded controls
    // ----------------------------------------------------------------
    waveform_mode_t wmode;
    clock_select_t csel;
    logic req;
    logic wr;
    logic rd;
    logic timer_tick;
    logic [15:0] top_val;
    logic dual_slope;
    logic capt_is_top;
    logic ovf_event;
    logic src_level;
    logic det_in;
    logic capture_event;
    logic flag_clr_ovf;
    logic flag_clr_capt;

    // Mode bits split over two control registers
    assign wmode = waveform_mode_t'({control_reg_b_reg[CTRLB_WGM_LSB +: 2],
                                     control_reg_a_reg[CTRLA_WGM_LSB +: 2]});
    assign csel = clock_select_t'(control_reg_b_reg[CTRLB_CS_LSB +: 3]);

    assign req = wb_req_i.cyc & wb_req_i.stb & ~ack_reg;
    assign wr = req & wb_req_i.we & wb_req_i.sel[0];
    assign rd = req & ~wb_req_i.we;

    // ----------------------------------------------------------------
    // Tick source
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            presc_reg <= '0;
        end else begin
            presc_reg <= presc_reg + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_sync_reg <= 3'h0;
        end else begin
            ext_sync_reg <= {ext_sync_reg[1:0], external_count_pin_i};
        end
    end

    always_comb begin
        case (csel)
            CS_STOP: timer_tick = 1'b0;
            CS_DIV1: timer_tick = 1'b1;
            CS_DIV8: timer_tick = &presc_reg[2:0];
            CS_DIV64: timer_tick = &presc_reg[5:0];
            CS_DIV256: timer_tick = &presc_reg[7:0];
            CS_DIV1024: timer_tick = &presc_reg[9:0];
            CS_EXT_FALL: timer_tick = ext_sync_reg[2] & ~ext_sync_reg[1];
            CS_EXT_RISE: timer_tick = ~ext_sync_reg[2] & ext_sync_reg[1];
            default: timer_tick = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // Counting sequence
    // ----------------------------------------------------------------
    always_comb begin
        dual_slope = 1'b0;
        capt_is_top = 1'b0;
        case (wmode)
            WM_PC8, WM_FAST8: top_val = TOP_8BIT;
            WM_PC9, WM_FAST9: top_val = TOP_9BIT;
            WM_PC10, WM_FAST10: top_val = TOP_10BIT;
            WM_CTC_CMPA, WM_PFC_CMPA, WM_PC_CMPA, WM_FAST_CMPA: top_val = compare_a_reg;
            WM_PFC_CAPT, WM_PC_CAPT, WM_CTC_CAPT, WM_FAST_CAPT: begin
                top_val = capture_value_reg;
                capt_is_top = 1'b1;
            end
            default: top_val = MAX_VAL;
        endcase
        case (wmode)
            WM_PC8, WM_PC9, WM_PC10, WM_PFC_CAPT, WM_PFC_CMPA, WM_PC_CAPT,
            WM_PC_CMPA: dual_slope = 1'b1;
            default: dual_slope = 1'b0;
        endcase
    end

    always_comb begin
        count_value_next = count_value_reg;
        count_down_next = count_down_reg;
        if (wr && wb_req_i.adr == ADDR_COUNT_LO) begin
            count_value_next = {holding_reg, wb_req_i.dat[7:0]};
        end else if (timer_tick) begin
            if (dual_slope) begin
                if (!count_down_reg && count_value_reg >= top_val) begin
                    count_down_next = 1'b1;
                    count_value_next = count_value_reg - 16'h0001;
                end else if (count_down_reg && count_value_reg == BOTTOM_VAL) begin
                    count_down_next = 1'b0;
                    count_value_next = count_value_reg + 16'h0001;
                end else if (count_down_reg) begin
                    count_value_next = count_value_reg - 16'h0001;
                end else begin
                    count_value_next = count_value_reg + 16'h0001;
                end
            end else if (count_value_reg == top_val) begin
                count_value_next = BOTTOM_VAL;
            end else begin
                // Past a lowered top the count runs on to MAX and wraps
                count_value_next = count_value_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_value_reg <= COUNT_RESET;
            count_down_reg <= 1'b0;
        end else begin
            count_value_reg <= count_value_next;
            count_down_reg <= count_down_next;
        end
    end

    // Overflow point depends on mode family
    always_comb begin
        case (wmode)
            WM_FAST8, WM_FAST9, WM_FAST10, WM_FAST_CAPT, WM_FAST_CMPA:
                ovf_event = timer_tick && count_value_reg == top_val;
            WM_PC8, WM_PC9, WM_PC10, WM_PFC_CAPT, WM_PFC_CMPA, WM_PC_CAPT, WM_PC_CMPA:
                ovf_event = timer_tick && count_down_reg && count_value_reg == BOTTOM_VAL;
            default: ovf_event = timer_tick && count_value_reg == MAX_VAL;
        endcase
    end

    assign top_o = count_value_reg == top_val;
    assign bottom_o = count_value_reg == BOTTOM_VAL;
    assign count_value_o = count_value_reg;

    // ----------------------------------------------------------------
    // Capture path
    // ----------------------------------------------------------------
    // Pin input is the pad level, so port-driven toggles also capture
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_sync_reg <= 2'h0;
            comp_sync_reg <= 2'h0;
        end else begin
            pin_sync_reg <= {pin_sync_reg[0], capture_pin_i};
            comp_sync_reg <= {comp_sync_reg[0], comparator_output_i};
        end
    end

    assign src_level = comparator_ctrl_status_reg[COMP_CAPSEL_BIT] ?
                       comp_sync_reg[1] : pin_sync_reg[1];

    // Four samples: three held plus the current one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            filt_hist_reg <= '0;
            filt_out_reg <= 1'b0;
        end else begin
            filt_hist_reg <= {filt_hist_reg[FILTER_SAMPLES-3:0], src_level};
            if (&{filt_hist_reg, src_level} || ~|{filt_hist_reg, src_level}) begin
                filt_out_reg <= src_level;
            end
        end
    end

    // Filter output lags the raw level by exactly four cycles
    assign det_in = control_reg_b_reg[CTRLB_NF_BIT] ? filt_out_reg : src_level;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            det_prev_reg <= 1'b0;
        end else begin
            det_prev_reg <= det_in;
        end
    end

    assign capture_event = !capt_is_top &&
                           (control_reg_b_reg[CTRLB_EDGE_BIT] ? (det_in & ~det_prev_reg)
                                                              : (~det_in & det_prev_reg));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            capture_value_reg <= COUNT_RESET;
        end else if (capture_event) begin
            capture_value_reg <= count_value_reg;
        end else if (wr && wb_req_i.adr == ADDR_CAPT_LO && capt_is_top) begin
            capture_value_reg <= {holding_reg, wb_req_i.dat[7:0]};
        end
    end

    // ----------------------------------------------------------------
    // Flags; a setting event wins over a same-cycle clear
    // ----------------------------------------------------------------
    assign flag_clr_ovf = overflow_irq_ack_i |
                          (wr && wb_req_i.adr == ADDR_FLAGS && wb_req_i.dat[OVF_BIT]);
    assign flag_clr_capt = capture_irq_ack_i |
                           (wr && wb_req_i.adr == ADDR_FLAGS && wb_req_i.dat[CAPT_BIT]);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            overflow_flag_reg <= 1'b0;
        end else if (ovf_event) begin
            overflow_flag_reg <= 1'b1;
        end else if (flag_clr_ovf) begin
            overflow_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            capture_flag_reg <= 1'b0;
        end else if (capture_event) begin
            capture_flag_reg <= 1'b1;
        end else if (flag_clr_capt) begin
            capture_flag_reg <= 1'b0;
        end
    end

    assign capture_irq_o = capture_flag_reg & irq_enable_reg[CAPT_BIT];
    assign overflow_irq_o = overflow_flag_reg & irq_enable_reg[OVF_BIT];

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    // Upper-byte holder is shared by all 16-bit registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            holding_reg <= 8'h00;
        end else if (wr && (wb_req_i.adr == ADDR_COUNT_HI || wb_req_i.adr == ADDR_CAPT_HI ||
                            wb_req_i.adr == ADDR_CMPA_HI)) begin
            holding_reg <= wb_req_i.dat[7:0];
        end else if (rd && wb_req_i.adr == ADDR_COUNT_LO) begin
            holding_reg <= count_value_reg[15:8];
        end else if (rd && wb_req_i.adr == ADDR_CAPT_LO) begin
            holding_reg <= capture_value_reg[15:8];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            control_reg_a_reg <= CTRL_RESET;
            control_reg_b_reg <= CTRL_RESET;
            comparator_ctrl_status_reg <= CTRL_RESET;
            irq_enable_reg <= CTRL_RESET;
            compare_a_reg <= COUNT_RESET;
        end else if (wr) begin
            case (wb_req_i.adr)
                ADDR_CTRL_A: control_reg_a_reg <= wb_req_i.dat[7:0];
                ADDR_CTRL_B: control_reg_b_reg <= wb_req_i.dat[7:0];
                ADDR_COMP_CS: comparator_ctrl_status_reg <= wb_req_i.dat[7:0];
                ADDR_IRQ_EN: irq_enable_reg <= wb_req_i.dat[7:0];
                ADDR_CMPA_LO: compare_a_reg <= {holding_reg, wb_req_i.dat[7:0]};
                default: ;
            endcase
        end
    end

    // Answer one cycle after the request; unmapped reads give zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= req;
            if (rd) begin
                case (wb_req_i.adr)
                    ADDR_COUNT_LO: dat_reg <= {24'h000000, count_value_reg[7:0]};
                    ADDR_COUNT_HI: dat_reg <= {24'h000000, holding_reg};
                    ADDR_CAPT_LO: dat_reg <= {24'h000000, capture_value_reg[7:0]};
                    ADDR_CAPT_HI: dat_reg <= {24'h000000, holding_reg};
                    ADDR_CMPA_LO: dat_reg <= {24'h000000, compare_a_reg[7:0]};
                    ADDR_CMPA_HI: dat_reg <= {24'h000000, compare_a_reg[15:8]};
                    ADDR_CTRL_A: dat_reg <= {24'h000000, control_reg_a_reg};
                    ADDR_CTRL_B: dat_reg <= {24'h000000, control_reg_b_reg};
                    ADDR_COMP_CS: dat_reg <= {24'h000000, comparator_ctrl_status_reg};
                    ADDR_IRQ_EN: dat_reg <= {24'h000000, irq_enable_reg};
                    ADDR_FLAGS: dat_reg <= {30'h00000000, capture_flag_reg, overflow_flag_reg};
                    default: dat_reg <= 32'h0000_0000;
                endcase
            end else begin
                dat_reg <= 32'h0000_0000;
            end
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

endmodule

// ---- common/timer16_pkg.sv ----
// Constants, types and register map of the 16-bit timer with input capture
// Summary of operation
// - Clock select field picks the tick source; zero selects none and stops counting.
// - Sixteen-bit counter counts up, down or clears on each tick per mode and direction.
// - Bottom shows when count is zero; top shows at the sequence's highest value.
// - Count sits in two bytes; upper goes via holder; lower read loads holder.
// - A software write to the count beats any same-cycle count or clear.
// - Count stays readable and writable whether or not a tick source runs.
// - The four-bit waveform mode field, split over control A and B, sets sequence.
// - Overflow flag sets where the mode says and may request an interrupt.
// - A matching edge on the chosen source copies the full count into capture.
// - Capture flag sets with the copy and requests an interrupt when enabled.
// - Capture flag clears on interrupt service or when software writes one to it.
// - Reading capture lower byte loads holder; later upper read returns the holder.
// - Capture accepts writes only in modes using it as top; otherwise ignored.
// - Comparator capture select makes the comparator, not the pin, trigger captures.
// - Enabled filter changes its output only after four agreeing samples.
// - Filter enable adds four system clock cycles before the capture update.
// - Filter samples on the system clock, independent of the prescaler.
// - Filter and edge detector stay active except in capture-as-top modes.
// - Pin level reaches the capture path even when the port drives the pin.
// - Each new capture overwrites the capture register, read or not.
// - Writing a lower byte loads holder and low byte into the register at once.
// - Top is 0xFFFF, 0x00FF, 0x01FF, 0x03FF, compare A or capture by mode; bottom 0x0000.
package timer16_pkg;

    // ----------------------------------------------------------------
    // Register byte addresses
    // ----------------------------------------------------------------
    localparam logic [5:0] ADDR_COUNT_LO = 6'h00;
    localparam logic [5:0] ADDR_COUNT_HI = 6'h04;
    localparam logic [5:0] ADDR_CAPT_LO = 6'h08;
    localparam logic [5:0] ADDR_CAPT_HI = 6'h0C;
    localparam logic [5:0] ADDR_CMPA_LO = 6'h10;
    localparam logic [5:0] ADDR_CMPA_HI = 6'h14;
    localparam logic [5:0] ADDR_CTRL_A = 6'h18;
    localparam logic [5:0] ADDR_CTRL_B = 6'h1C;
    localparam logic [5:0] ADDR_COMP_CS = 6'h20;
    localparam logic [5:0] ADDR_IRQ_EN = 6'h24;
    localparam logic [5:0] ADDR_FLAGS = 6'h28;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTRLA_WGM_LSB = 0;
    localparam int CTRLB_CS_LSB = 0;
    localparam int CTRLB_WGM_LSB = 3;
    localparam int CTRLB_EDGE_BIT = 6;
    localparam int CTRLB_NF_BIT = 7;
    localparam int COMP_CAPSEL_BIT = 2;
    localparam int OVF_BIT = 0;
    localparam int CAPT_BIT = 1;

    // ----------------------------------------------------------------
    // Reset values and fixed counts
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] BOTTOM_VAL = 16'h0000;
    localparam logic [15:0] MAX_VAL = 16'hFFFF;
    localparam logic [15:0] TOP_8BIT = 16'h00FF;
    localparam logic [15:0] TOP_9BIT = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;
    localparam int FILTER_SAMPLES = 4;
    localparam int PRESC_WIDTH = 10;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        CS_STOP = 3'h0, CS_DIV1 = 3'h1, CS_DIV8 = 3'h2, CS_DIV64 = 3'h3,
        CS_DIV256 = 3'h4, CS_DIV1024 = 3'h5, CS_EXT_FALL = 3'h6, CS_EXT_RISE = 3'h7
    } clock_select_t;

    typedef enum logic [3:0] {
        WM_NORMAL = 4'h0, WM_PC8 = 4'h1, WM_PC9 = 4'h2, WM_PC10 = 4'h3,
        WM_CTC_CMPA = 4'h4, WM_FAST8 = 4'h5, WM_FAST9 = 4'h6, WM_FAST10 = 4'h7,
        WM_PFC_CAPT = 4'h8, WM_PFC_CMPA = 4'h9, WM_PC_CAPT = 4'hA, WM_PC_CMPA = 4'hB,
        WM_CTC_CAPT = 4'hC, WM_RSVD = 4'hD, WM_FAST_CAPT = 4'hE, WM_FAST_CMPA = 4'hF
    } waveform_mode_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [5:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_t;

endpackage

// ---- test/event_source_model.sv ----
// Behavioural source of capture events on the pin and comparator lines
`timescale 1ns/1ps
module event_source_model (
    input wire logic clk_i,
    output logic capture_pin_o,
    output logic comparator_output_o
);
    // Pad level reaches the timer whether the port drives the pin or not
    initial begin
        capture_pin_o = 1'b0;
        comparator_output_o = 1'b0;
    end
    task automatic drive(input logic comp, input logic level);
        @(posedge clk_i);
        if (comp) begin
            comparator_output_o <= level;
        end else begin
            capture_pin_o <= level;
        end
    endtask
endmodule

// ---- test/timer16_monitor.sv ----
// Port-level assertions for the 16-bit timer with input capture
`timescale 1ns/1ps
module timer16_monitor (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire timer16_pkg::wb_req_t wb_req_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic capture_pin_i,
    input wire logic comparator_output_i,
    input wire logic capture_irq_ack_i,
    input wire logic capture_irq_o,
    input wire logic bottom_o,
    input wire logic [15:0] count_value_o
);
    import timer16_pkg::*;
    // ----------------------------------------------------------------
    // Shadow of the shared upper-byte holder
    // ----------------------------------------------------------------
    logic taken;
    logic cnt_wr;
    logic [7:0] hold_reg;
    logic hold_ok_reg;
    logic [3:0] quiet_reg;
    assign taken = wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
    assign cnt_wr = taken && wb_req_i.we && wb_req_i.adr == ADDR_COUNT_LO;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_reg <= 8'h00;
            hold_ok_reg <= 1'b1;
        end else if (taken && wb_req_i.we && wb_req_i.sel[0] && (wb_req_i.adr == ADDR_COUNT_HI
                || wb_req_i.adr == ADDR_CAPT_HI || wb_req_i.adr == ADDR_CMPA_HI)) begin
            hold_reg <= wb_req_i.dat[7:0];
            hold_ok_reg <= 1'b1;
        end else if (taken && !wb_req_i.we && wb_req_i.adr == ADDR_COUNT_LO) begin
            hold_reg <= count_value_o[15:8];
            hold_ok_reg <= 1'b1;
        end else if (taken && !wb_req_i.we && wb_req_i.adr == ADDR_CAPT_LO) begin
            hold_ok_reg <= 1'b0;
        end
    end
    // Writes and source changes may start a capture, so they restart the quiet count
    always_ff @(posedge clk_i) begin
        if (rst_i || !$stable(capture_pin_i) || !$stable(comparator_output_i)
                || (taken && wb_req_i.we)) begin
            quiet_reg <= 4'h0;
        end else if (quiet_reg != 4'hF) begin
            quiet_reg <= quiet_reg + 4'h1;
        end
    end
    sequence s_req;
        wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
    endsequence
    sequence s_hi_read;
        taken && !wb_req_i.we && hold_ok_reg
            && (wb_req_i.adr == ADDR_COUNT_HI || wb_req_i.adr == ADDR_CAPT_HI);
    endsequence
    AST_ACK_LAT: assert property (@(posedge clk_i) disable iff (rst_i) s_req |=> wb_ack_o)
        else $error("ack not one cycle after request");
    AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(wb_ack_o) |-> $past(wb_req_i.cyc && wb_req_i.stb))
        else $error("ack without request");
    AST_DAT_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_dat_o[31:8] == 24'h0 && (wb_ack_o || wb_dat_o == 32'h0))
        else $error("read data outside ack or above byte");
    AST_BOTTOM: assert property (@(posedge clk_i) disable iff (rst_i)
        bottom_o == (count_value_o == BOTTOM_VAL))
        else $error("bottom does not follow zero count");
    AST_COUNT_STEP: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(cnt_wr) |-> count_value_o == $past(count_value_o)
        || count_value_o == $past(count_value_o) + 16'h0001
        || count_value_o == $past(count_value_o) - 16'h0001 || count_value_o == BOTTOM_VAL)
        else $error("count moved by more than one");
    AST_COUNT_WR: assert property (@(posedge clk_i) disable iff (rst_i)
        cnt_wr && wb_req_i.sel[0] && hold_ok_reg
        |=> count_value_o == {$past(hold_reg), $past(wb_req_i.dat[7:0])})
        else $error("count write lost or mixed with count");
    AST_HOLD_RD: assert property (@(posedge clk_i) disable iff (rst_i)
        s_hi_read |=> wb_dat_o == {24'h0, $past(hold_reg)})
        else $error("upper read not from holder");
    AST_IRQ_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
        capture_irq_ack_i && quiet_reg >= 4'h8 |=> !capture_irq_o)
        else $error("capture flag not cleared by service");
endmodule

// ---- test/timer16_counter_input_capture_tb_top.sv ----
// Self-checking bench for the 16-bit timer with input capture
`timescale 1ns/1ps
module timer16_counter_input_capture_tb_top;
    import timer16_pkg::*;
    logic clk_i;
    logic rst_i;
    wb_req_t wb_req;
    logic [31:0] wb_dat;
    logic wb_ack;
    logic cap_pin;
    logic comp_out;
    logic cap_ack;
    logic ovf_ack;
    logic cap_irq;
    logic ovf_irq;
    logic top;
    logic bottom;
    logic [15:0] count;
    int miscompares;
    int cmp_count;
    int cycles;
    int seed;
    logic [7:0] exp_q[$];
    logic [15:0] v;
    timer16_counter_input_capture uut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req),
        .wb_dat_o(wb_dat), .wb_ack_o(wb_ack), .capture_pin_i(cap_pin),
        .comparator_output_i(comp_out), .external_count_pin_i(cap_pin),
        .capture_irq_ack_i(cap_ack), .overflow_irq_ack_i(ovf_ack), .capture_irq_o(cap_irq),
        .overflow_irq_o(ovf_irq), .top_o(top), .bottom_o(bottom), .count_value_o(count));
    event_source_model src (.clk_i(clk_i), .capture_pin_o(cap_pin), .comparator_output_o(comp_out));
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Bus cycles, scoreboard and capture timing
    // ----------------------------------------------------------------
    task automatic bus(input logic we, input logic [5:0] adr, input logic [7:0] d);
        @(posedge clk_i);
        wb_req <= '{1'b1, 1'b1, we, adr, 4'h1, {24'h0, d}};
        @(posedge clk_i);
        while (wb_ack !== 1'b1) begin
            @(posedge clk_i);
        end
        wb_req <= '0;
    endtask
    task automatic rd(input logic [5:0] adr, input logic [7:0] e);
        exp_q.push_back(e);
        bus(1'b0, adr, 8'h00);
    endtask
    always @(posedge clk_i) begin
        if (wb_ack === 1'b1 && wb_req.we === 1'b0 && exp_q.size() > 0) begin
            check(wb_dat, {24'h0, exp_q.pop_front()});
        end
        cycles++;
        if (cycles > 20000) begin
            miscompares++;
            print_verdict();
        end
    end
    // Flag must stay low until exactly lat edges after the source change
    task automatic edge_at(input logic comp, input logic level, input int lat, input logic hit);
        src.drive(comp, level);
        repeat (lat - 1) @(posedge clk_i);
        #1 check(cap_irq, 1'b0);
        @(posedge clk_i);
        #1 check(cap_irq, hit);
    endtask
    initial begin
        seed = 4606;
        wb_req = '0;
        rst_i = 1'b1;
        cap_ack = 1'b0;
        ovf_ack = 1'b0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1 check(bottom, 1'b1);
        check(top, 1'b0);
        rd(ADDR_CTRL_B, CTRL_RESET);
        rd(ADDR_FLAGS, 8'h00);
        rd(6'h3C, 8'h00);
        $display("Test reset done");
        repeat (3) begin
            v = 16'($random(seed));
            bus(1'b1, ADDR_COUNT_HI, v[15:8]);
            bus(1'b1, ADDR_COUNT_LO, v[7:0]);
            repeat (4) @(posedge clk_i);
            rd(ADDR_COUNT_LO, v[7:0]);
            rd(ADDR_COUNT_HI, v[15:8]);
        end
        $display("Test stopped count done");
        bus(1'b1, ADDR_IRQ_EN, 8'h03);
        bus(1'b1, ADDR_COUNT_HI, 8'hFF);
        bus(1'b1, ADDR_COUNT_LO, 8'hF0);
        bus(1'b1, ADDR_CTRL_B, 8'h01);
        repeat (30) @(posedge clk_i);
        #1 check(ovf_irq, 1'b1);
        @(posedge clk_i);
        ovf_ack <= 1'b1;
        @(posedge clk_i);
        ovf_ack <= 1'b0;
        #1 check(ovf_irq, 1'b0);
        bus(1'b1, ADDR_COUNT_HI, 8'h12);
        bus(1'b1, ADDR_COUNT_LO, 8'h34);
        bus(1'b1, ADDR_CTRL_B, 8'h00);
        $display("Test counting done");
        v = 16'($random(seed));
        bus(1'b1, ADDR_COUNT_HI, v[15:8]);
        bus(1'b1, ADDR_COUNT_LO, v[7:0]);
        bus(1'b1, ADDR_CTRL_B, 8'h47);
        bus(1'b1, ADDR_FLAGS, 8'h02);
        edge_at(1'b0, 1'b1, 3, 1'b1);
        rd(ADDR_CAPT_LO, v[7:0]);
        rd(ADDR_CAPT_HI, v[15:8]);
        rd(ADDR_COUNT_LO, v[7:0] + 8'h01);
        bus(1'b1, ADDR_FLAGS, 8'h02);
        rd(ADDR_FLAGS, 8'h00);
        v = 16'($random(seed));
        bus(1'b1, ADDR_COUNT_HI, v[15:8]);
        bus(1'b1, ADDR_COUNT_LO, v[7:0]);
        bus(1'b1, ADDR_CTRL_B, 8'h80);
        bus(1'b1, ADDR_FLAGS, 8'h02);
        edge_at(1'b0, 1'b0, 7, 1'b1);
        rd(ADDR_CAPT_LO, v[7:0]);
        repeat (8) @(posedge clk_i);
        cap_ack <= 1'b1;
        @(posedge clk_i);
        cap_ack <= 1'b0;
        #1 check(cap_irq, 1'b0);
        src.drive(1'b0, 1'b1);
        src.drive(1'b0, 1'b0);
        repeat (10) @(posedge clk_i);
        #1 check(cap_irq, 1'b0);
        $display("Test capture done");
        bus(1'b1, ADDR_CTRL_B, 8'h40);
        bus(1'b1, ADDR_COMP_CS, 8'h04);
        bus(1'b1, ADDR_FLAGS, 8'h02);
        edge_at(1'b0, 1'b1, 3, 1'b0);
        edge_at(1'b1, 1'b1, 3, 1'b1);
        bus(1'b1, ADDR_COMP_CS, 8'h00);
        bus(1'b1, ADDR_CAPT_HI, 8'h3C);
        bus(1'b1, ADDR_CAPT_LO, 8'h5A);
        rd(ADDR_CAPT_LO, v[7:0]);
        bus(1'b1, ADDR_CTRL_B, 8'h58);
        bus(1'b1, ADDR_CAPT_HI, 8'h3C);
        bus(1'b1, ADDR_CAPT_LO, 8'h5A);
        bus(1'b1, ADDR_CMPA_LO, 8'h77);
        rd(ADDR_CMPA_HI, 8'h3C);
        bus(1'b1, ADDR_FLAGS, 8'h02);
        edge_at(1'b0, 1'b0, 3, 1'b0);
        edge_at(1'b0, 1'b1, 3, 1'b0);
        rd(ADDR_CAPT_LO, 8'h5A);
        rd(ADDR_CAPT_HI, 8'h3C);
        $display("Test source and mode done");
        print_verdict();
    end
endmodule
bind timer16_counter_input_capture timer16_monitor mon (.clk_i(clk_i), .rst_i(rst_i),
    .wb_req_i(wb_req_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .capture_pin_i(capture_pin_i), .comparator_output_i(comparator_output_i),
    .capture_irq_ack_i(capture_irq_ack_i), .capture_irq_o(capture_irq_o),
    .bottom_o(bottom_o), .count_value_o(count_value_o));
